// >>> rtl/pvs_defines.svh
// register map, field positions and frame counts of the status and interrupt bank
`ifndef PVS_DEFINES_SVH
`define PVS_DEFINES_SVH
// ---------------------------------------------------------------
// register offsets on the management interface
// ---------------------------------------------------------------
`define PVS_REG_CFG      5'h10
`define PVS_REG_STAT2    5'h11
`define PVS_REG_IRQEN    5'h12
`define PVS_REG_IRQST    5'h13
// ---------------------------------------------------------------
// configuration, interrupt enable and interrupt status fields
// ---------------------------------------------------------------
`define PVS_CFG_RST      3'h0
`define PVS_CFG_ALTNP    1
`define PVS_IRQEN_RST    16'h0000
`define PVS_IE_MASK_HI   7
`define PVS_IE_MASK_LO   4
`define PVS_IE_GLOBAL    1
`define PVS_IE_FORCE     0
`define PVS_IS_PEND      2
// ---------------------------------------------------------------
// live status field positions
// ---------------------------------------------------------------
`define PVS_S2_SPEED     14
`define PVS_S2_TX        13
`define PVS_S2_RX        12
`define PVS_S2_COL       11
`define PVS_S2_LINK      10
`define PVS_S2_DUP       9
`define PVS_S2_AN        8
`define PVS_S2_AUTONEG_DONE_FLAG    7
`define PVS_S2_POL       5
`define PVS_S2_PAUSE     4
`define PVS_S2_ERR       3
// ---------------------------------------------------------------
// event flag order inside the 4-bit flag vector
// ---------------------------------------------------------------
`define PVS_FL_AN        3
`define PVS_FL_LNK       0
// ---------------------------------------------------------------
// serial frame counts
// ---------------------------------------------------------------
`define PVS_PRE_LEN      6'd32
`define PVS_OP_RD        2'b10
`define PVS_OP_WR        2'b01
`define PVS_OP_LAST      6'd1
`define PVS_ADDR_LAST    6'd9
`define PVS_RD_LAST      6'd16
`define PVS_WR_LAST      6'd17
`endif

// >>> rtl/pvs_pkg.sv
// types shared by the status and interrupt bank
package pvs_pkg;
   typedef logic [4:0]  pvs_addr_t;   // station address on the serial bus
   typedef logic [15:0] pvs_word_t;   // one management register
   // serial frame engine states, one-hot
   typedef enum logic [6:0] {
      ST_PRE     = 7'b0000001,
      ST_START   = 7'b0000010,
      ST_OP      = 7'b0000100,
      ST_ADDR    = 7'b0001000,
      ST_TA_RD   = 7'b0010000,
      ST_DATA_RD = 7'b0100000,
      ST_DATA_WR = 7'b1000000
   } pvs_state_t;
endpackage : pvs_pkg

// >>> rtl/pvs_irq_if.sv
// bundle between the register bank and the event latch
`timescale 1ns/1ps
interface pvs_irq_if;
   logic       speed;      // live 100 Mb/s
   logic       duplex;     // live full duplex
   logic       link;       // live link up
   logic       an_done;    // live negotiation complete
   logic [3:0] mask;       // per-event enables
   logic       global_en;  // global interrupt enable
   logic       force_irq;  // test force
   logic       rd_clr;     // one-cycle pulse: status register read
   logic [3:0] flags;      // latched events
   logic       pending;    // interrupt pending
   modport regs   (output speed, duplex, link, an_done, mask, global_en, force_irq, rd_clr,
                   input flags, pending);
   modport events (input speed, duplex, link, an_done, mask, global_en, force_irq, rd_clr,
                   output flags, pending);
endinterface : pvs_irq_if

// >>> rtl/pvs_irq_events.sv
// event latch and interrupt gate
`timescale 1ns/1ps
`include "pvs_defines.svh"
module pvs_irq_events (
   input wire logic clk_i,
   input wire logic rst_n_i,
   pvs_irq_if.events ev
);
   import pvs_pkg::*;
   logic [3:0] live;      // current levels in flag order
   logic [3:0] prev_q;    // levels one cycle ago
   logic [3:0] chg;       // change seen this cycle
   logic [3:0] flags_q;   // sticky event flags
   logic       irq_q;     // registered interrupt pending

   assign live = {ev.an_done, ev.speed, ev.duplex, ev.link};
   // negotiation only reports completion, the others any edge
   assign chg  = {live[`PVS_FL_AN] & ~prev_q[`PVS_FL_AN], live[2:0] ^ prev_q[2:0]};

   // ---------------------------------------------------------------
   // change detection and sticky flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) prev_q <= 4'h0;
      else          prev_q <= live;
   end

   // set wins over the read clear so no event is lost
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) flags_q <= 4'h0;
      else          flags_q <= (flags_q & ~{4{ev.rd_clr}}) | chg;
   end

   // ---------------------------------------------------------------
   // interrupt gate
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) irq_q <= 1'b0;
      else          irq_q <= ev.force_irq
                             | (ev.global_en & |(flags_q & ev.mask));
   end

   assign ev.flags   = flags_q;
   assign ev.pending = irq_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   gate_off_a: assert property (!ev.global_en && !ev.force_irq |=> !ev.pending)
      else $error("interrupt raised while globally disabled");
   force_on_a: assert property (ev.force_irq |=> ev.pending)
      else $error("force did not raise interrupt");
   mask_path_a: assert property (ev.global_en && |(ev.flags & ev.mask) |=> ev.pending)
      else $error("enabled event did not raise interrupt");
   masked_off_a: assert property (!ev.force_irq && (ev.flags & ev.mask) == 4'h0 |=> !ev.pending)
      else $error("masked events raised interrupt");
   link_latch_a: assert property ($changed(ev.link) |=> ev.flags[`PVS_FL_LNK])
      else $error("link change not latched");
   rd_clear_a: assert property (ev.rd_clr && chg == 4'h0 |=> ev.flags == 4'h0)
      else $error("read did not clear flags");
   irq_event_c: cover property (!ev.pending ##1 ev.pending && !ev.force_irq);
endmodule : pvs_irq_events

// >>> rtl/pvs_top.sv
// serial management slave with configuration, live status and interrupt registers
`timescale 1ns/1ps
`include "pvs_defines.svh"

// What this block does
// - config bit 1 enables alternate next page
// - config bits 2,0 reserved read/write, reset 0
// - status bit 14 shows 100 Mb/s operation
// - status bit 13 shows transmit in progress
// - status bit 12 shows receive in progress
// - bits 11,10,9: collision, link, full duplex
// - status bit 8 shows negotiation mode
// - status bit 7 mirrors negotiation complete
// - status bit 5 shows reversed polarity
// - status bit 4 shows pause capability
// - status bit 3 shows error or remote fault
// - enable bit 7 masks negotiation-done event
// - enable bit 6 masks speed change event
// - enable bit 5 masks duplex change event
// - enable bit 4 masks link change event
// - enable bit 1 gates event interrupts, not the force
// - enable bit 0 forces interrupt output
// - enable reserved bits written zero, ignored
// - change flags latch, clear on status read
// - status bit 2 shows interrupt pending
module pvs_top #(
   parameter pvs_pkg::pvs_addr_t PHY_ADDR = 5'h00   // station address this slave answers
) (
   input  wire logic SYS_CLK_I,
   input  wire logic RST_N_I,
   input  wire logic MDC_I,
   input  wire logic MDIO_I,
   output logic      MDIO_O,
   output logic      MDIO_OE_O,
   input  wire logic SPEED_100_I,
   input  wire logic TX_ACTIVE_I,
   input  wire logic RX_ACTIVE_I,
   input  wire logic COLLISION_I,
   input  wire logic LINK_UP_I,
   input  wire logic FULL_DUPLEX_I,
   input  wire logic AUTONEG_MODE_I,
   input  wire logic AUTONEG_DONE_I,
   input  wire logic POLARITY_REV_I,
   input  wire logic PAUSE_CAP_I,
   input  wire logic ERROR_I,
   output logic      ALT_NEXT_PAGE_EN_O,
   output logic      MGMT_IRQ_OUT_O
);
   import pvs_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic        mdc_s1_q;      // first sync stage of the clock pin
   logic        mdc_s2_q;      // second sync stage
   logic        mdc_s3_q;      // delayed copy for edge detect
   logic        mdio_s1_q;     // first sync stage of the data pin
   logic        mdio_s2_q;     // second sync stage
   logic        mdc_rise;      // one-cycle pulse on management clock rise
   logic        bit_in;        // data bit sampled with that rise

   pvs_state_t  state_q;       // frame engine state
   logic [5:0]  cnt_q;         // bit counter within a field
   logic [1:0]  op_q;          // opcode
   logic [9:0]  addr_q;        // station and register address
   logic [9:0]  addr_full;     // address including the bit arriving now
   logic        hit;           // station address matches
   logic        wr_hit_q;      // write frame aimed at this slave
   logic [4:0]  reg_q;         // register of the current frame
   logic [15:0] wdata_q;       // incoming write data
   logic [15:0] wdata_full;    // write data including the bit arriving now
   logic        rd_load;       // read frame accepted, load shifter
   logic        wr_now;        // last write bit arrived
   pvs_word_t   rd_shift_q;    // outgoing read data
   pvs_word_t   rd_word;       // register selected for reading
   pvs_word_t   stat2;         // assembled live status
   logic        mdio_q;        // registered pin data
   logic        mdio_oe_q;     // registered pin enable

   logic [2:0]  cfg_q;         // stored configuration bits
   pvs_word_t   irqen_q;       // interrupt enable register

   pvs_irq_if   irq_bus ();    // link to the event latch

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // both pins are asynchronous to the system clock
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         mdc_s1_q  <= 1'b0;
         mdc_s2_q  <= 1'b0;
         mdc_s3_q  <= 1'b0;
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
      end else begin
         mdc_s1_q  <= MDC_I;
         mdc_s2_q  <= mdc_s1_q;
         mdc_s3_q  <= mdc_s2_q;
         mdio_s1_q <= MDIO_I;
         mdio_s2_q <= mdio_s1_q;
      end
   end

   // data and clock see the same delay, so the bit is sampled at the rise
   assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
   assign bit_in   = mdio_s2_q;

   // ---------------------------------------------------------------
   // frame decode helpers
   // ---------------------------------------------------------------
   assign addr_full  = {addr_q[8:0], bit_in};
   assign wdata_full = {wdata_q[14:0], bit_in};
   assign hit        = (addr_full[9:5] == PHY_ADDR);
   assign rd_load    = mdc_rise && (state_q == ST_ADDR) && (cnt_q == `PVS_ADDR_LAST)
                       && (op_q == `PVS_OP_RD) && hit;
   assign wr_now     = mdc_rise && (state_q == ST_DATA_WR) && (cnt_q == `PVS_WR_LAST)
                       && wr_hit_q;

   // ---------------------------------------------------------------
   // frame engine
   // ---------------------------------------------------------------
   // a broken frame falls back to preamble hunting
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         state_q <= ST_PRE;
         cnt_q   <= 6'd0;
      end else if (mdc_rise) begin
         case (state_q)
            ST_PRE: begin
               if (bit_in) begin
                  // saturate so a long idle still counts as preamble
                  if (cnt_q != `PVS_PRE_LEN) cnt_q <= cnt_q + 6'd1;
               end else if (cnt_q == `PVS_PRE_LEN) begin
                  state_q <= ST_START;  // first start bit seen
                  cnt_q   <= 6'd0;
               end else begin
                  cnt_q   <= 6'd0;
               end
            end
            ST_START: begin
               state_q <= bit_in ? ST_OP : ST_PRE;
               cnt_q   <= 6'd0;
            end
            ST_OP: begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == `PVS_OP_LAST) begin
                  state_q <= ST_ADDR;
                  cnt_q   <= 6'd0;
               end
            end
            ST_ADDR: begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == `PVS_ADDR_LAST) begin
                  // foreign or unknown frames ride the write path silently
                  state_q <= rd_load ? ST_TA_RD : ST_DATA_WR;
                  cnt_q   <= 6'd0;
               end
            end
            ST_TA_RD: begin
               state_q <= ST_DATA_RD;
               cnt_q   <= 6'd0;
            end
            ST_DATA_RD: begin
               if (cnt_q == `PVS_RD_LAST) begin
                  state_q <= ST_PRE;
                  cnt_q   <= 6'd0;
               end else begin
                  cnt_q <= cnt_q + 6'd1;
               end
            end
            ST_DATA_WR: begin
               // turnaround bits are shifted with the data and fall off the top
               if (cnt_q == `PVS_WR_LAST) begin
                  state_q <= ST_PRE;
                  cnt_q   <= 6'd0;
               end else begin
                  cnt_q <= cnt_q + 6'd1;
               end
            end
            default: begin
               state_q <= ST_PRE;
               cnt_q   <= 6'd0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // field shifters
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         op_q     <= 2'b00;
         addr_q   <= 10'h000;
         wdata_q  <= 16'h0000;
         reg_q    <= 5'h00;
         wr_hit_q <= 1'b0;
      end else if (mdc_rise) begin
         if (state_q == ST_OP)      op_q    <= {op_q[0], bit_in};
         if (state_q == ST_ADDR)    addr_q  <= addr_full;
         if (state_q == ST_DATA_WR) wdata_q <= wdata_full;
         if (state_q == ST_ADDR && cnt_q == `PVS_ADDR_LAST) begin
            reg_q    <= addr_full[4:0];
            wr_hit_q <= (op_q == `PVS_OP_WR) && hit;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   // the live status is assembled here; unlisted bits stay zero
   always_comb begin
      stat2                  = 16'h0000;
      stat2[`PVS_S2_SPEED]   = SPEED_100_I;
      stat2[`PVS_S2_TX]      = TX_ACTIVE_I;
      stat2[`PVS_S2_RX]      = RX_ACTIVE_I;
      stat2[`PVS_S2_COL]     = COLLISION_I;
      stat2[`PVS_S2_LINK]    = LINK_UP_I;
      stat2[`PVS_S2_DUP]     = FULL_DUPLEX_I;
      stat2[`PVS_S2_AN]      = AUTONEG_MODE_I;
      stat2[`PVS_S2_AUTONEG_DONE_FLAG]  = AUTONEG_DONE_I;
      stat2[`PVS_S2_POL]     = POLARITY_REV_I;
      stat2[`PVS_S2_PAUSE]   = PAUSE_CAP_I;
      stat2[`PVS_S2_ERR]     = ERROR_I;
   end

   // register select; unmapped offsets read zero
   always_comb begin
      case (addr_full[4:0])
         `PVS_REG_CFG:   rd_word = {13'h0000, cfg_q};
         `PVS_REG_STAT2: rd_word = stat2;
         `PVS_REG_IRQEN: rd_word = irqen_q;
         `PVS_REG_IRQST: rd_word = {8'h00, irq_bus.flags, 1'b0,
                                    irq_bus.pending, 2'b00};
         default:        rd_word = 16'h0000;
      endcase
   end

   // status is frozen at the address phase, so one frame reads one snapshot
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I)                                       rd_shift_q <= 16'h0000;
      else if (rd_load)                                   rd_shift_q <= rd_word;
      else if (mdc_rise && state_q == ST_DATA_RD)         rd_shift_q <= rd_shift_q << 1;
   end

   // ---------------------------------------------------------------
   // pin driver
   // ---------------------------------------------------------------
   // drive changes just after the rise; the controller samples on the next one
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         mdio_q    <= 1'b1;
         mdio_oe_q <= 1'b0;
      end else if (mdc_rise) begin
         case (state_q)
            ST_TA_RD: begin
               mdio_q    <= 1'b0;   // second turnaround bit
               mdio_oe_q <= 1'b1;
            end
            ST_DATA_RD: begin
               mdio_q    <= rd_shift_q[15];
               mdio_oe_q <= (cnt_q != `PVS_RD_LAST);
            end
            default: begin
               mdio_q    <= 1'b1;
               mdio_oe_q <= 1'b0;
            end
         endcase
      end
   end

   assign MDIO_O    = mdio_q;
   assign MDIO_OE_O = mdio_oe_q;

   // ---------------------------------------------------------------
   // writable registers
   // ---------------------------------------------------------------
   // reserved bits are kept as written; software is expected to write zero
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I)                              cfg_q <= `PVS_CFG_RST;
      else if (wr_now && reg_q == `PVS_REG_CFG)  cfg_q <= wdata_full[2:0];
   end

   // the live status register has no write branch at all
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I)                               irqen_q <= `PVS_IRQEN_RST;
      else if (wr_now && reg_q == `PVS_REG_IRQEN) irqen_q <= wdata_full;
   end

   assign ALT_NEXT_PAGE_EN_O = cfg_q[`PVS_CFG_ALTNP];

   // ---------------------------------------------------------------
   // event latch
   // ---------------------------------------------------------------
   assign irq_bus.speed     = SPEED_100_I;
   assign irq_bus.duplex    = FULL_DUPLEX_I;
   assign irq_bus.link      = LINK_UP_I;
   assign irq_bus.an_done   = AUTONEG_DONE_I;
   assign irq_bus.mask      = irqen_q[`PVS_IE_MASK_HI:`PVS_IE_MASK_LO];
   assign irq_bus.global_en = irqen_q[`PVS_IE_GLOBAL];
   assign irq_bus.force_irq = irqen_q[`PVS_IE_FORCE];
   // reading the status register clears the flags it just reported
   assign irq_bus.rd_clr    = rd_load && (addr_full[4:0] == `PVS_REG_IRQST);

   pvs_irq_events u_events (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .ev      (irq_bus)
   );

   assign MGMT_IRQ_OUT_O = irq_bus.pending;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   alt_np_write_a: assert property (
      wr_now && reg_q == `PVS_REG_CFG |=> ALT_NEXT_PAGE_EN_O == $past(wdata_full[1]))
      else $error("alternate next page enable not updated");
   cfg_reserved_a: assert property (
      wr_now && reg_q == `PVS_REG_CFG |=> cfg_q[2] == $past(wdata_full[2])
                                         && cfg_q[0] == $past(wdata_full[0]))
      else $error("reserved config bits not stored");
   speed_read_a: assert property (
      rd_load && addr_full[4:0] == `PVS_REG_STAT2 |=> rd_shift_q[14] == $past(SPEED_100_I))
      else $error("speed bit wrong in status read");
   activity_read_a: assert property (
      rd_load && addr_full[4:0] == `PVS_REG_STAT2
      |=> rd_shift_q[13:9] == $past({TX_ACTIVE_I, RX_ACTIVE_I, COLLISION_I,
                                     LINK_UP_I, FULL_DUPLEX_I}))
      else $error("activity bits wrong in status read");
   autoneg_done_flag_read_a: assert property (
      rd_load && addr_full[4:0] == `PVS_REG_STAT2
      |=> rd_shift_q[8:7] == $past({AUTONEG_MODE_I, AUTONEG_DONE_I})
          && rd_shift_q[5:3] == $past({POLARITY_REV_I, PAUSE_CAP_I, ERROR_I}))
      else $error("negotiation or fault bits wrong in status read");
   stat2_zero_a: assert property (
      rd_load && addr_full[4:0] == `PVS_REG_STAT2
      |=> rd_shift_q[15] == 1'b0 && rd_shift_q[6] == 1'b0 && rd_shift_q[2:0] == 3'b000)
      else $error("reserved status bits not zero");
   stat2_write_a: assert property (
      wr_now && reg_q == `PVS_REG_STAT2 |=> $stable(cfg_q) && $stable(irqen_q))
      else $error("write to live status changed a register");
   pend_read_a: assert property (
      rd_load && addr_full[4:0] == `PVS_REG_IRQST |=> rd_shift_q[2] == $past(MGMT_IRQ_OUT_O))
      else $error("pending bit differs from interrupt output");
   irq_force_a: assert property (
      irqen_q[`PVS_IE_FORCE] ##1 irqen_q[`PVS_IE_FORCE] |-> MGMT_IRQ_OUT_O)
      else $error("forced interrupt not on output");
   drive_window_a: assert property (
      MDIO_OE_O |-> state_q == ST_DATA_RD)
      else $error("data pin driven outside a read frame");

   read_frame_c:  cover property (rd_load ##[1:1000] state_q == ST_PRE);
   write_frame_c: cover property (wr_now && reg_q == `PVS_REG_IRQEN);
   clear_read_c:  cover property (irq_bus.rd_clr && irq_bus.flags != 4'h0);
endmodule : pvs_top

// >>> verification/pvs_mgmt_host.sv
// management controller model framing reads and writes on the serial pins
`timescale 1ns/1ps
module pvs_mgmt_host (
   output logic        mdc_o,   // management clock, stands low between frames
   output logic        mdio_o,  // level this controller drives
   output logic        oe_o,    // high while this controller drives
   input  wire logic   mdio_i,  // resolved wire, pulled up when released
   output logic        rv_o,    // pulse once a read word is complete
   output logic [15:0] rd_o     // last sixteen bits seen at the rises
);
   initial begin
      {mdc_o, mdio_o, oe_o, rv_o} = 4'h4;
      rd_o = 16'h0000;
   end
   // one bit: change mid low phase, sample the wire at the rise
   task automatic bit_t(input logic b, input logic drv);
      mdc_o = 1'b0;
      #50 mdio_o = b;
      oe_o = drv;
      #50 mdc_o = 1'b1;
      rd_o = {rd_o[14:0], mdio_i};
      #100;
   endtask : bit_t
   // reads let go of the wire from the first turnaround bit on
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
      logic [63:0] f;
      f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
      for (int i = 63; i >= 0; i--) bit_t(f[i], (i > 17) || (op == 2'b01));
      mdc_o = 1'b0;
      oe_o = 1'b0;
      #100 rv_o = (op == 2'b10);
      #4 rv_o = 1'b0;
   endtask : xfer
endmodule : pvs_mgmt_host

// >>> verification/tb_pvs_top.sv
// self-checking bench for the status and interrupt register bank
`timescale 1ns/1ps
module tb_pvs_top;
   logic        clk = 1'b0;     // system clock
   logic        rst_n = 1'b0;   // synchronous reset, low active
   logic [10:0] st = '0;        // live levels, speed down to error
   logic        mdc, h_bit, h_oe, d_bit, d_oe, rv, irq, altnp;
   logic [15:0] rd;             // word read by the controller
   wire  logic  mdio = d_oe ? d_bit : (h_oe ? h_bit : 1'b1);
   int          err_total = 0;
   int          tests_run = 0;
   logic [15:0] exp_q[$];       // expected read words, oldest first
   int          ev_pos[4] = '{6, 5, 10, 3};  // link, duplex, speed, autoneg-done
   pvs_top i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .MDC_I(mdc), .MDIO_I(mdio), .MDIO_O(d_bit),
      .MDIO_OE_O(d_oe), .SPEED_100_I(st[10]), .TX_ACTIVE_I(st[9]), .RX_ACTIVE_I(st[8]),
      .COLLISION_I(st[7]), .LINK_UP_I(st[6]), .FULL_DUPLEX_I(st[5]), .AUTONEG_MODE_I(st[4]),
      .AUTONEG_DONE_I(st[3]), .POLARITY_REV_I(st[2]), .PAUSE_CAP_I(st[1]), .ERROR_I(st[0]),
      .ALT_NEXT_PAGE_EN_O(altnp), .MGMT_IRQ_OUT_O(irq));
   pvs_mgmt_host i_host (.mdc_o(mdc), .mdio_o(h_bit), .oe_o(h_oe), .mdio_i(mdio), .rv_o(rv),
      .rd_o(rd));
   always #2 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      tests_run++;
      if (got !== ex) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, ex);
      end
   endtask : chk
   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      i_host.xfer(2'b01, 5'h00, ra, wd);
   endtask : wr
   task automatic rdc(input logic [4:0] ra, input logic [15:0] ex, input logic [4:0] pa = 5'h00);
      exp_q.push_back(ex);
      i_host.xfer(2'b10, pa, ra, 16'h0000);
   endtask : rdc
   // levels move 1 ns after an edge, then flags and output settle
   task automatic set_st(input logic [10:0] v);
      @(posedge clk);
      #1 st = v;
      repeat (6) @(posedge clk);
   endtask : set_st
   task automatic irq_is(input logic e);
      #1 chk({15'h0000, irq}, {15'h0000, e});
   endtask : irq_is
   // each finished read is matched against the oldest note
   always @(posedge rv) begin
      if (exp_q.size() != 0) chk(rd, exp_q.pop_front());
      else begin
         err_total++;
         $display("MISMATCH t=%0t read with no expected word", $time);
      end
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #400us;
      err_total++;
      finish_test();
   end
   initial begin
      void'($urandom(52));
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      rdc(5'h10, 16'h0000);
      rdc(5'h12, 16'h0000);
      rdc(5'h11, 16'h0000);
      wr(5'h10, 16'h0002);
      irq_is(1'b0);
      chk({15'h0000, altnp}, 16'h0001);
      rdc(5'h10, 16'h0002);
      i_host.xfer(2'b11, 5'h00, 5'h10, 16'h0000);  // opcode 11 frame must be ignored
      chk({15'h0000, altnp}, 16'h0001);
      wr(5'h11, 16'hFFFF);
      rdc(5'h11, 16'h0000);
      rdc(5'h1F, 16'h0000);
      rdc(5'h10, 16'hFFFF, 5'h01);  // another station's frame stays unanswered
      for (int i = 0; i < 4; i++) begin
         wr(5'h12, 16'h0002 | (16'h0010 << i));
         set_st(st | (11'h001 << ev_pos[i]));
         irq_is(1'b1);
         rdc(5'h13, (16'h0010 << i) | 16'h0004);
         irq_is(1'b0);
      end
      wr(5'h12, 16'h0002);
      set_st(st & 11'h7BF);
      irq_is(1'b0);
      rdc(5'h13, 16'h0010);
      wr(5'h12, 16'h00F0);
      set_st(st & 11'h3FF);
      irq_is(1'b0);
      rdc(5'h13, 16'h0040);
      wr(5'h12, 16'h0001);
      irq_is(1'b1);
      wr(5'h12, 16'h0000);
      irq_is(1'b0);
      for (int i = 0; i < 3; i++) begin
         set_st(11'($urandom));
         rdc(5'h11, {1'b0, st[10:3], 1'b0, st[2:0], 3'b000});
      end
      // mid-run reset with the bus idle must clear the configuration again
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      chk({15'h0000, altnp}, 16'h0000);
      irq_is(1'b0);
      finish_test();
   end
endmodule : tb_pvs_top
